// [rtl/rvmc_pkg.sv]
// package for the reset and voltage monitor control block
// assumes one 10 MHz core clock and an 8-bit plain register port
`default_nettype none

package rvmc_pkg;

  // core clock
  localparam int unsigned CLK_PERIOD_NS = 100;

  // register port widths
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // register indices
  localparam logic [3:0] ADDR_PROTECT   = 4'h0;
  localparam logic [3:0] ADDR_PMODE0    = 4'h1;
  localparam logic [3:0] ADDR_PMODE1    = 4'h2;
  localparam logic [3:0] ADDR_DET_STAT  = 4'h3;
  localparam logic [3:0] ADDR_DET_EN    = 4'h4;
  localparam logic [3:0] ADDR_L1_CTRL   = 4'h5;
  localparam logic [3:0] ADDR_L2_CTRL   = 4'h6;

  // field positions
  localparam int unsigned PROT_MON_WE_BIT   = 3;
  localparam int unsigned PM0_SW_RESET_BIT  = 3;
  localparam int unsigned PM1_WDT_RESET_BIT = 2;
  localparam int unsigned STAT_L2_CMP_BIT   = 3;
  localparam int unsigned EN_DET1_BIT       = 6;
  localparam int unsigned EN_DET2_BIT       = 7;
  localparam int unsigned MC_ENABLE_BIT     = 0;
  localparam int unsigned MC_FILT_DIS_BIT   = 1;
  localparam int unsigned MC_FLAG_BIT       = 2;
  localparam int unsigned MC_AUX_BIT        = 3;
  localparam int unsigned MC_DIV_LSB        = 4;
  localparam int unsigned MC_MODE_BIT       = 6;
  localparam int unsigned MC_EDGE_BIT       = 7;

  // reset values
  localparam logic [7:0] RST_PROTECT = 8'h00;
  localparam logic [7:0] RST_PMODE1  = 8'h00;
  localparam logic [7:0] RST_DET_EN  = 8'h00;
  localparam logic [7:0] RST_L1_CTRL = 8'h80;
  localparam logic [7:0] RST_L2_CTRL = 8'h80;
  localparam logic [7:0] READ_ZERO   = 8'h00;

  // timing
  localparam int unsigned SETTLE_DELAY_NS  = 100000;
  localparam int unsigned SETTLE_CYCLES    =
    (SETTLE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned L1_RELEASE_TICKS = 32;
  localparam int unsigned FILTER_SAMPLES   = 4;
  localparam int unsigned RESET_HOLD       = 16;

  typedef enum logic [2:0] {
    RVMC_RUN  = 3'b001,
    RVMC_HOLD = 3'b010,
    RVMC_L1   = 3'b100
  } rvmc_state_t;

endpackage

`default_nettype wire

// [rtl/rvmc_core.sv]
// reset source combining and supply voltage detector control
// assumes async comparator levels, a same-clock low-speed oscillator tick
// and a same-clock watchdog underflow pulse
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - level-two falling crossing in reset mode resets pins, cpu and registers.
// - every internal reset reselects low-speed oscillator divided by eight.
// - internal ram is never cleared by these resets.
// - watchdog underflow resets the chip when watchdog reset select is 1.
// - writing 1 to the software reset bit resets the chip.
// - detector one has no readable result; detector two has a status bit.
// - level-one reset holds while supply is low, releases after recovery.
// - filtered level-two requests both crossings; unfiltered only selected one.
// - level-two compare status reads 1 while detector two is disabled.
// - a detector ignores its input until the settle delay after enabling.
// - detect status and enable registers survive internal resets.
// - rewriting a monitor control register may set its flag; software clears.
// - level-one monitor enable acts only while detector one is enabled.
// - level-two monitor enable acts only while detector two is enabled.
// - writing 0 clears the level-two flag, writing 1 leaves it.
// - level-two edge select acts only with the filter disabled.
// - level-two flag and aux status survive internal resets.
// - level-one monitor control survives internal resets.
// - filter needs four sampling clock cycles before a level is trusted.
module rvmc_core
  import rvmc_pkg::*;
#(
  parameter int unsigned SETTLE_CNT = SETTLE_CYCLES,
  parameter int unsigned HOLD_CNT   = RESET_HOLD
) (
  // clock and power-on reset
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  // analog comparators, high while supply is above threshold
  input  wire logic              cmp_one_above_i,
  input  wire logic              cmp_two_above_i,
  // timing and watchdog
  input  wire logic              low_speed_osc_tick_i,
  input  wire logic              wdt_underflow_i,
  // system side
  output logic                   sys_reset_o,
  output logic                   cpu_clk_default_o,
  output logic                   level_two_irq_o
);

  localparam int unsigned CW = $clog2(SETTLE_CNT + 1);
  localparam int unsigned HW = $clog2(HOLD_CNT + 1);
  localparam logic [CW-1:0] SETTLE_LOAD = CW'(SETTLE_CNT);
  localparam logic [HW-1:0] HOLD_LOAD   = HW'(HOLD_CNT);
  localparam logic [5:0]    L1_TICKS    = 6'(L1_RELEASE_TICKS);
  localparam logic [1:0]    FILT_LAST   = 2'(FILTER_SAMPLES - 1);

  // sampling mask for divide-by-n, n = 1, 2, 4, 8
  function automatic logic [2:0] div_mask(input logic [1:0] sel);
    case (sel)
      2'h0:    div_mask = 3'h0;
      2'h1:    div_mask = 3'h1;
      2'h2:    div_mask = 3'h3;
      default: div_mask = 3'h7;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0]  protect_reg;
  logic [7:0]  processor_mode_reg_one;
  logic [7:0]  detect_enable_reg;
  logic [7:0]  level_one_monitor_ctrl;
  logic [7:0]  level_two_monitor_ctrl;
  logic        int_reset;
  logic        mon_we;
  logic        wr_prot;
  logic        wr_pm0;
  logic        wr_pm1;
  logic        wr_en;
  logic        wr_l1;
  logic        wr_l2;
  logic [1:0]  det_en;
  logic [1:0]  filt_dis;
  logic [1:0]  ready;
  logic [1:0]  rearm;
  logic [1:0]  rise_ev;
  logic [1:0]  fall_ev;
  logic [1:0]  level;
  logic [1:0]  raw;
  logic [1:0]  cmp_in;
  logic [1:0]  div_sel [0:1];
  logic        l1_active;
  logic        l2_active;
  logic        l2_event;
  logic        l1_event;
  logic        l2_reset_req;
  logic        sw_reset_req;
  logic        wdt_reset_req;
  logic        reset_req;
  logic        level_two_compare_status;

  assign mon_we  = protect_reg[PROT_MON_WE_BIT];
  assign wr_prot = reg_wr_i && (reg_addr_i == ADDR_PROTECT);
  assign wr_pm0  = reg_wr_i && (reg_addr_i == ADDR_PMODE0);
  assign wr_pm1  = reg_wr_i && (reg_addr_i == ADDR_PMODE1);
  assign wr_en   = reg_wr_i && mon_we && (reg_addr_i == ADDR_DET_EN);
  assign wr_l1   = reg_wr_i && mon_we && (reg_addr_i == ADDR_L1_CTRL);
  assign wr_l2   = reg_wr_i && mon_we && (reg_addr_i == ADDR_L2_CTRL);

  // protect and mode registers are ordinary and clear on any reset
  always_ff @(posedge core_clk_i) begin
    if (rst_i || int_reset) begin
      protect_reg            <= RST_PROTECT;
      processor_mode_reg_one <= RST_PMODE1;
    end else begin
      if (wr_prot) begin
        protect_reg <= reg_wdata_i;
      end
      if (wr_pm1) begin
        processor_mode_reg_one <= reg_wdata_i;
      end
    end
  end

  // detector enables only clear on power-on reset
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      detect_enable_reg <= RST_DET_EN;
    end else if (wr_en) begin
      detect_enable_reg <= reg_wdata_i;
    end
  end

  // a level-one write stores its flag bit as written, a level-two write can only
  // clear its flag; software still clears after a rewrite because a crossing can land during the write
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      level_one_monitor_ctrl <= RST_L1_CTRL;
    end else begin
      if (wr_l1) begin
        level_one_monitor_ctrl <= reg_wdata_i;
      end
      if (l1_event) begin
        level_one_monitor_ctrl[MC_FLAG_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      level_two_monitor_ctrl <= RST_L2_CTRL;
    end else begin
      if (wr_l2) begin
        level_two_monitor_ctrl <= {reg_wdata_i[7:MC_FLAG_BIT+1],
                                   level_two_monitor_ctrl[MC_FLAG_BIT]
                                   & reg_wdata_i[MC_FLAG_BIT],
                                   reg_wdata_i[MC_FLAG_BIT-1:0]};
      end
      // set wins over a clearing write in the same cycle
      if (l2_event) begin
        level_two_monitor_ctrl[MC_FLAG_BIT] <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // per-detector synchroniser, settle delay and digital filter

  assign det_en     = {detect_enable_reg[EN_DET2_BIT],
                       detect_enable_reg[EN_DET1_BIT]};
  assign filt_dis   = {level_two_monitor_ctrl[MC_FILT_DIS_BIT],
                       level_one_monitor_ctrl[MC_FILT_DIS_BIT]};
  assign div_sel[0] = level_one_monitor_ctrl[MC_DIV_LSB+1:MC_DIV_LSB];
  assign div_sel[1] = level_two_monitor_ctrl[MC_DIV_LSB+1:MC_DIV_LSB];
  assign cmp_in     = {cmp_two_above_i, cmp_one_above_i};
  // a 0 to 1 write of filter disable drops the stale filter state
  assign rearm      = {wr_l2 && !filt_dis[1] && reg_wdata_i[MC_FILT_DIS_BIT],
                       wr_l1 && !filt_dis[0] && reg_wdata_i[MC_FILT_DIS_BIT]};

  for (genvar d = 0; d < 2; d++) begin : g_det
    logic          sync_a;
    logic          sync_b;
    logic          en_q;
    logic [CW-1:0] settle;
    logic [2:0]    div_cnt;
    logic [1:0]    agree;
    logic          filt;
    logic          samp_en;

    assign samp_en = low_speed_osc_tick_i
                     && ((div_cnt & div_mask(div_sel[d])) == 3'h0);

    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        sync_a <= 1'b1;
        sync_b <= 1'b1;
      end else begin
        sync_a <= cmp_in[d];
        sync_b <= sync_a;
      end
    end

    // counting starts again on every 0 to 1 change of the enable
    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        en_q   <= 1'b0;
        settle <= '0;
      end else begin
        en_q <= det_en[d];
        if (!det_en[d]) begin
          settle <= '0;
        end else if (!en_q) begin
          settle <= SETTLE_LOAD;
        end else if (settle != '0) begin
          settle <= settle - CW'(1);
        end
      end
    end

    assign ready[d] = det_en[d] && en_q && (settle == '0);

    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        div_cnt <= 3'h0;
      end else if (low_speed_osc_tick_i) begin
        div_cnt <= div_cnt + 3'h1;
      end
    end

    // filtered level moves only after four samples in a row disagree
    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        filt        <= 1'b1;
        agree       <= 2'h0;
        rise_ev[d]  <= 1'b0;
        fall_ev[d]  <= 1'b0;
      end else begin
        rise_ev[d] <= 1'b0;
        fall_ev[d] <= 1'b0;
        if (!ready[d] || rearm[d]) begin
          filt  <= sync_b;
          agree <= 2'h0;
        end else if (filt_dis[d]) begin
          filt       <= sync_b;
          agree      <= 2'h0;
          rise_ev[d] <= sync_b && !filt;
          fall_ev[d] <= !sync_b && filt;
        end else if (samp_en) begin
          if (sync_b == filt) begin
            agree <= 2'h0;
          end else if (agree == FILT_LAST) begin
            filt       <= sync_b;
            agree      <= 2'h0;
            rise_ev[d] <= sync_b;
            fall_ev[d] <= !sync_b;
          end else begin
            agree <= agree + 2'h1;
          end
        end
      end
    end

    assign level[d] = filt;
    assign raw[d]   = sync_b;
  end

  //////////////////////////////////////////////////////////////////////////////
  // detection events and reset requests

  assign l1_active = level_one_monitor_ctrl[MC_ENABLE_BIT]
                     && ready[0];
  assign l2_active = level_two_monitor_ctrl[MC_ENABLE_BIT]
                     && ready[1];
  assign l1_event  = l1_active && fall_ev[0];

  // edge select only counts with the filter off
  always_comb begin
    l2_event = 1'b0;
    if (l2_active) begin
      if (filt_dis[1]) begin
        l2_event = level_two_monitor_ctrl[MC_EDGE_BIT] ? fall_ev[1]
                                                       : rise_ev[1];
      end else begin
        l2_event = fall_ev[1] || rise_ev[1];
      end
    end
  end

  // software is expected to pick the falling edge in reset mode
  assign l2_reset_req  = l2_event
                         && level_two_monitor_ctrl[MC_MODE_BIT]
                         && !level[1];
  assign sw_reset_req  = wr_pm0 && reg_wdata_i[PM0_SW_RESET_BIT];
  assign wdt_reset_req = wdt_underflow_i
                         && processor_mode_reg_one[PM1_WDT_RESET_BIT];
  assign reset_req     = l2_reset_req || sw_reset_req || wdt_reset_req;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      level_two_irq_o <= 1'b0;
    end else begin
      level_two_irq_o <= l2_event
                         && !level_two_monitor_ctrl[MC_MODE_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // reset sequencer

  rvmc_state_t   state;
  logic [HW-1:0] hold_cnt;
  logic [5:0]    tick_cnt;

  // level-one low supply takes priority over a running hold
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state    <= RVMC_RUN;
      hold_cnt <= '0;
      tick_cnt <= 6'h00;
    end else begin
      case (state)
        RVMC_RUN: begin
          if (l1_active && !level[0]) begin
            state    <= RVMC_L1;
            tick_cnt <= 6'h00;
          end else if (reset_req) begin
            state    <= RVMC_HOLD;
            hold_cnt <= HOLD_LOAD;
          end
        end
        RVMC_HOLD: begin
          if (l1_active && !level[0]) begin
            state    <= RVMC_L1;
            tick_cnt <= 6'h00;
          end else if (hold_cnt <= HW'(1)) begin
            state    <= RVMC_RUN;
            hold_cnt <= '0;
          end else begin
            hold_cnt <= hold_cnt - HW'(1);
          end
        end
        RVMC_L1: begin
          // released after 32 oscillator ticks above the threshold
          if (!raw[0]) begin
            tick_cnt <= 6'h00;
          end else if (tick_cnt == L1_TICKS) begin
            state    <= RVMC_HOLD;
            hold_cnt <= HOLD_LOAD;
          end else if (low_speed_osc_tick_i) begin
            tick_cnt <= tick_cnt + 6'h01;
          end
        end
        default: begin
          state <= RVMC_RUN;
        end
      endcase
    end
  end

  // internal ram has no reset path here, so a write cut short stays corrupt
  assign int_reset         = (state != RVMC_RUN);
  assign sys_reset_o       = int_reset;
  // clock controller loads low-speed oscillator / 8 while this is high
  assign cpu_clk_default_o = int_reset || rst_i;

  //////////////////////////////////////////////////////////////////////////////
  // read path

  // compare status only means something once detector two has settled
  assign level_two_compare_status = det_en[1] ? raw[1] : 1'b1;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= READ_ZERO;
    end else if (reg_rd_i) begin
      if (reg_addr_i == ADDR_PROTECT) begin
        reg_rdata_o <= protect_reg;
      end else if (reg_addr_i == ADDR_PMODE1) begin
        reg_rdata_o <= processor_mode_reg_one;
      end else if (reg_addr_i == ADDR_DET_STAT) begin
        reg_rdata_o <= READ_ZERO
                       | (8'(level_two_compare_status) << STAT_L2_CMP_BIT);
      end else if (reg_addr_i == ADDR_DET_EN) begin
        reg_rdata_o <= detect_enable_reg;
      end else if (reg_addr_i == ADDR_L1_CTRL) begin
        reg_rdata_o <= level_one_monitor_ctrl;
      end else if (reg_addr_i == ADDR_L2_CTRL) begin
        reg_rdata_o <= level_two_monitor_ctrl;
      end else begin
        reg_rdata_o <= READ_ZERO;
      end
    end else begin
      reg_rdata_o <= READ_ZERO;
    end
  end

endmodule

`default_nettype wire

// [dv/rvmc_core_sva.sv]
// checker for the reset and voltage monitor control block
// sees only core ports; shadows protect, mode and enable bits from writes
`default_nettype none

module rvmc_core_sva
  import rvmc_pkg::*;
#(
  parameter int unsigned HOLD_CNT = RESET_HOLD
) (
  // clock, reset and register port
  input wire logic              core_clk_i,
  input wire logic              rst_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic              reg_wr_i,
  input wire logic              reg_rd_i,
  input wire logic [DATA_W-1:0] reg_rdata_o,
  // comparators, timing and watchdog
  input wire logic              cmp_one_above_i,
  input wire logic              cmp_two_above_i,
  input wire logic              low_speed_osc_tick_i,
  input wire logic              wdt_underflow_i,
  // system side
  input wire logic              sys_reset_o,
  input wire logic              cpu_clk_default_o,
  input wire logic              level_two_irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        prot;
  logic        wdt_sel;
  logic [7:0]  en;
  int unsigned hi_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // internal reset clears protect and watchdog select only
  always_ff @(posedge core_clk_i) begin
    if (rst_i || sys_reset_o) begin
      prot    <= 1'b0;
      wdt_sel <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == ADDR_PROTECT) begin
      prot <= reg_wdata_i[PROT_MON_WE_BIT];
    end else if (reg_wr_i && reg_addr_i == ADDR_PMODE1) begin
      wdt_sel <= reg_wdata_i[PM1_WDT_RESET_BIT];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      en <= RST_DET_EN;
    end else if (reg_wr_i && reg_addr_i == ADDR_DET_EN && prot) begin
      en <= reg_wdata_i;
    end
  end

  // number of samples the internal reset has stood high
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !sys_reset_o) begin
      hi_cnt <= 0;
    end else begin
      hi_cnt <= hi_cnt + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  sw_reset_a: assert property (
    reg_wr_i && reg_addr_i == ADDR_PMODE0 && reg_wdata_i[PM0_SW_RESET_BIT]
    && !sys_reset_o |=> sys_reset_o && cpu_clk_default_o)
    else $error("software reset not raised");
  clk_default_a: assert property (
    sys_reset_o |-> cpu_clk_default_o)
    else $error("cpu clock default missing in reset");
  hold_len_a: assert property (
    $fell(sys_reset_o) |-> hi_cnt >= HOLD_CNT)
    else $error("internal reset too short");
  wdt_reset_a: assert property (
    wdt_underflow_i && wdt_sel && !sys_reset_o |=> sys_reset_o)
    else $error("watchdog underflow did not reset");
  stat_idle_a: assert property (
    reg_rd_i && reg_addr_i == ADDR_DET_STAT && !en[EN_DET2_BIT]
    |=> reg_rdata_o[STAT_L2_CMP_BIT])
    else $error("status not 1 with detector two off");
  irq_gate_a: assert property (
    level_two_irq_o |-> en[EN_DET2_BIT])
    else $error("interrupt with detector two off");
  irq_pulse_a: assert property (
    $rose(level_two_irq_o) |=> !level_two_irq_o)
    else $error("interrupt longer than one cycle");
  en_keep_a: assert property (
    reg_rd_i && reg_addr_i == ADDR_DET_EN
    |=> reg_rdata_o[7:6] == en[7:6])
    else $error("enable register readback wrong");
endmodule

bind rvmc_core rvmc_core_sva #(.HOLD_CNT(HOLD_CNT)) i_sva (
  .core_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
  .reg_rdata_o, .cmp_one_above_i, .cmp_two_above_i, .low_speed_osc_tick_i,
  .wdt_underflow_i, .sys_reset_o, .cpu_clk_default_o, .level_two_irq_o
);

`default_nettype wire

// [dv/rvmc_supply_model.sv]
// supply comparators and low-speed oscillator seen by the block
// assumes the bench sets the supply levels; comparators lag them slightly
`default_nettype none

module rvmc_supply_model #(
  parameter int unsigned TICK_DIV = 4
) (
  // clock and supply levels
  input  wire logic clk_i,
  input  wire logic above_one_i,
  input  wire logic above_two_i,
  // comparator and oscillator outputs
  output wire logic cmp_one_above_o,
  output wire logic cmp_two_above_o,
  output var logic  osc_tick_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned cnt = 0;

  // async lag so the block must synchronise the levels
  assign #7 cmp_one_above_o = above_one_i;
  assign #7 cmp_two_above_o = above_two_i;

  // oscillator kept running so filter sampling always advances
  always_ff @(posedge clk_i) begin
    cnt        <= (cnt == TICK_DIV - 1) ? 0 : cnt + 1;
    osc_tick_o <= (cnt == TICK_DIV - 1);
  end
endmodule

`default_nettype wire

// [dv/rvmc_core_test.sv]
// self-checking bench for the reset and voltage monitor control block
// assumes the supply model drives comparators and the oscillator tick
`default_nettype none

module rvmc_core_test;
  timeunit 1ns;
  timeprecision 1ns;
  import rvmc_pkg::*;
  localparam int HOLD = 2;
  logic       core_clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic       reg_wr_i = 1'b0;
  logic       reg_rd_i = 1'b0;
  logic       wdt_underflow_i = 1'b0;
  logic       sup1 = 1'b1;
  logic       sup2 = 1'b1;
  wire logic [7:0] reg_rdata_o;
  wire logic  cmp_one_above_i;
  wire logic  cmp_two_above_i;
  wire logic  low_speed_osc_tick_i;
  wire logic  sys_reset_o;
  wire logic  cpu_clk_default_o;
  wire logic  level_two_irq_o;
  int         errors = 0;
  int         num_checks = 0;
  int         seed = 32'h045f80dd;
  int         mreg [16];

  always #50 core_clk_i = ~core_clk_i;

  rvmc_core #(.SETTLE_CNT(4), .HOLD_CNT(HOLD)) i_dut (
    .core_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .cmp_one_above_i, .cmp_two_above_i, .low_speed_osc_tick_i,
    .wdt_underflow_i, .sys_reset_o, .cpu_clk_default_o, .level_two_irq_o
  );

  rvmc_supply_model #(.TICK_DIV(4)) i_sup (
    .clk_i(core_clk_i), .above_one_i(sup1), .above_two_i(sup2),
    .cmp_one_above_o(cmp_one_above_i), .cmp_two_above_o(cmp_two_above_i),
    .osc_tick_o(low_speed_osc_tick_i)
  );

  ////////////////////////////////////////////////////////////////////////////
  task results;
    if (errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task chk(input bit ok, input string m);
    num_checks++;
    if (!ok) begin
      errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  // model view of a register; status bit follows supply once enabled
  function automatic logic [7:0] ex(input int a);
    if (a == 3)
      return mreg[4][7] ? {4'h0, sup2, 3'h0} : 8'h08;
    return (a == 1 || a > 6) ? 8'h00 : 8'(mreg[a]);
  endfunction

  function automatic logic [7:0] mk(input int a);
    return (a == 3) ? 8'h08 : ((a == 4) ? 8'hc0 : 8'hff);
  endfunction

  task irst;
    mreg[0] = RST_PROTECT;
    mreg[2] = RST_PMODE1;
  endtask

  task wr(input int a, input logic [7:0] d);
    logic [7:0] o;
    o = 8'(mreg[a]);
    @(posedge core_clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= 4'(a);
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    if (a == 0 || a == 2)
      mreg[a] = d;
    if (a == 1 && d[3])
      irst();
    // level-one flag is stored as written; only level-two flag is clear-only
    if (a >= 4 && a <= 6 && mreg[0][3])
      mreg[a] = (a == 6) ? {d[7:3], o[2] & d[2], d[1:0]} : d;
  endtask

  task rd(input int a, input logic [7:0] m);
    @(posedge core_clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= 4'(a);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk((reg_rdata_o & m) === (ex(a) & m), "read data mismatch");
  endtask

  // b selects reset (1) or interrupt (0); e says whether v must be seen
  task waitfor(input bit b, input logic v, input int lim, input bit e);
    bit s;
    s = 1'b0;
    for (int i = 0; i < lim && !s; i++) begin
      @(posedge core_clk_i);
      #1;
      s = ((b ? sys_reset_o : level_two_irq_o) === v);
    end
    chk(s == e, "event timing mismatch");
  endtask

  task wdog;
    @(posedge core_clk_i);
    wdt_underflow_i <= 1'b1;
    @(posedge core_clk_i);
    wdt_underflow_i <= 1'b0;
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // run needs under 1000 cycles; 30000-cycle limit leaves ample margin
  initial begin
    #3000000;
    errors++;
    results();
  end

  initial begin
    logic [7:0] d;
    mreg = '{default: 0};
    mreg[5] = RST_L1_CTRL;
    mreg[6] = RST_L2_CTRL;
    repeat (16) @(posedge core_clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 16; a++) rd(a, mk(a));
    wr(4, 8'hc0);
    rd(4, 8'hc0);
    wr(0, 8'h08);
    wr(3, 8'h00);
    rd(3, 8'h08);
    repeat (4) begin
      d = 8'($random(seed));
      d[0] = 1'b0;
      if (d[6]) d[7] = 1'b1;
      wr(5, d);
      wr(6, d);
      rd(5, 8'hff);
      rd(6, 8'hff);
    end
    // detector two, unfiltered falling crossing
    wr(4, 8'h80);
    repeat (10) @(posedge core_clk_i);
    rd(3, 8'h08);
    wr(6, 8'h82);
    wr(6, 8'h83);
    @(posedge core_clk_i) sup2 <= 1'b0;
    waitfor(0, 1, 20, 1);
    mreg[6] = mreg[6] | 4;
    rd(3, 8'h08);
    rd(6, 8'hff);
    wr(6, 8'h86);
    rd(6, 8'hff);
    wr(6, 8'h82);
    rd(6, 8'hff);
    // filtered: both crossings request
    wr(6, 8'h80);
    repeat (40) @(posedge core_clk_i);
    wr(6, 8'h81);
    @(posedge core_clk_i) sup2 <= 1'b1;
    waitfor(0, 1, 200, 1);
    @(posedge core_clk_i) sup2 <= 1'b0;
    waitfor(0, 1, 200, 1);
    wr(6, 8'h80);
    @(posedge core_clk_i) sup2 <= 1'b1;
    // software reset keeps monitor registers
    wr(1, 8'h08);
    #1;
    chk(sys_reset_o === 1'b1 && cpu_clk_default_o === 1'b1, "soft");
    waitfor(1, 0, HOLD + 2, 1);
    for (int a = 0; a < 7; a++) rd(a, mk(a));
    wdog();
    chk(sys_reset_o === 1'b0, "watchdog reset unselected");
    wr(2, 8'h04);
    rd(2, 8'hff);
    wdog();
    chk(sys_reset_o === 1'b1, "watchdog reset missing");
    irst();
    waitfor(1, 0, HOLD + 2, 1);
    for (int a = 0; a < 7; a++) rd(a, mk(a));
    // level-two reset mode
    wr(0, 8'h08);
    wr(6, 8'hc2);
    wr(6, 8'hc3);
    @(posedge core_clk_i) sup2 <= 1'b0;
    waitfor(1, 1, 20, 1);
    irst();
    waitfor(1, 0, HOLD + 2, 1);
    rd(6, 8'hfb);
    wr(0, 8'h08);
    wr(6, 8'h82);
    @(posedge core_clk_i) sup2 <= 1'b1;
    // level-one reset, first with detector one off
    wr(4, 8'h80);
    wr(5, 8'h82);
    wr(5, 8'h83);
    @(posedge core_clk_i) sup1 <= 1'b0;
    waitfor(1, 1, 20, 0);
    // supply already low: nothing may happen before the settle delay ends
    wr(4, 8'hc0);
    waitfor(1, 1, 3, 0);
    waitfor(1, 1, 20, 1);
    repeat (60) @(posedge core_clk_i);
    chk(sys_reset_o === 1'b1, "released while supply low");
    @(posedge core_clk_i) sup1 <= 1'b1;
    repeat (100) @(posedge core_clk_i);
    chk(sys_reset_o === 1'b1, "released before 32 ticks");
    waitfor(1, 0, 300, 1);
    irst();
    rd(5, 8'hfb);
    wr(0, 8'h08);
    wr(5, 8'h80);
    wr(4, 8'h00);
    rd(4, 8'hc0);
    results();
  end
endmodule

`default_nettype wire
